// file: hdl/dsl_pkg.sv
package dsl_pkg;

	localparam int         FRAME_BITS    = 32;
	localparam int         NIB_PER_FRAME = 8;
	localparam int         FIFO_DEPTH    = 16;
	localparam int         FIFO_WIDTH    = 4;
	localparam logic [7:0] CRC_POLY      = 8'h2f;
	localparam logic [7:0] CRC_SEED      = 8'hff;
	localparam logic [3:0] CMD_READ      = 4'h0;
	localparam logic [3:0] CMD_WRITE     = 4'h8;

	localparam int CLK_PERIOD_NS = 10;
	localparam int CHIP_TIME_NS  = 3000;
	localparam int CHIP_CYCLES   = CHIP_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		LVL_Q = 2'h0,
		LVL_1 = 2'h1,
		LVL_2 = 2'h2
	} dsl_lvl_t;

	// Three chips per nibble, first chip in bits 5:4.
	localparam logic [15:0][5:0] SYM_TAB = {
		6'h19, 6'h11, 6'h20, 6'h18, 6'h29, 6'h1a, 6'h24, 6'h28,
		6'h21, 6'h16, 6'h26, 6'h10, 6'h22, 6'h12, 6'h25, 6'h14
	};

	typedef enum logic [4:0] {
		DSL_RX   = 5'h01,
		DSL_CHK  = 5'h02,
		DSL_REG  = 5'h04,
		DSL_CRC  = 5'h08,
		DSL_PUSH = 5'h10
	} dsl_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [3:0] cmd;
		logic [7:0] ext;
		logic [7:0] data;
		logic [7:0] crc;
	} dsl_frame_t;

	typedef struct packed {
		logic       valid;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dsl_reg_req_t;

	function automatic logic [7:0] dsl_crc_step(input logic [7:0] c,
		input logic b);
		dsl_crc_step = {c[6:0], b} ^ (c[7] ? CRC_POLY : 8'h00);
	endfunction

	function automatic logic [7:0] dsl_crc_run(input logic [31:0] bits);
		logic [7:0] c;
		c = CRC_SEED;
		for (int i = 31; i >= 0; i--) begin
			c = dsl_crc_step(c, bits[i]);
		end
		dsl_crc_run = c;
	endfunction

endpackage

// file: hdl/dsl_fifo.sv
`timescale 1ns/100ps
module dsl_fifo import dsl_pkg::*; #(
	parameter int W     = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic         ref_clk,   // Clock.
	input  wire logic         rst_n,     // Async reset, active low.
	input  wire logic         in_valid,  // Write request.
	input  wire logic [W-1:0] in_data,   // Write data.
	output logic              in_ready,  // Room for a word.
	output logic              out_valid, // Read data present.
	output logic [W-1:0]      out_data,  // Read data, registered.
	input  wire logic         out_ready  // Reader takes the word.
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    ov;
		logic [W-1:0]            od;
	} dsl_fifo_st_t;

	dsl_fifo_st_t s_ff;
	dsl_fifo_st_t nxt_s;
	logic         push;
	logic         pop;

	assign in_ready  = (s_ff.cnt != (AW+1)'(DEPTH));
	assign out_valid = s_ff.ov;
	assign out_data  = s_ff.od;

	always_comb begin
		nxt_s = s_ff;
		push  = in_valid && in_ready;
		pop   = (!s_ff.ov || out_ready) && (s_ff.cnt != '0);
		if (out_ready) begin
			nxt_s.ov = 1'b0;
		end
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp           = s_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_s.od = s_ff.mem[s_ff.rp];
			nxt_s.ov = 1'b1;
			nxt_s.rp = s_ff.rp + 1'b1;
		end
		if (push && !pop) begin
			nxt_s.cnt = s_ff.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_s.cnt = s_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

endmodule

// file: hdl/dsl_chip_tx.sv
`timescale 1ns/100ps
module dsl_chip_tx import dsl_pkg::*; #(
	parameter int CHIP_CYC = CHIP_CYCLES
) (
	input  wire logic       ref_clk,   // Clock.
	input  wire logic       rst_n,     // Async reset, active low.
	input  wire logic       sym_valid, // Nibble waiting.
	input  wire logic [3:0] sym_data,  // Nibble to send.
	output logic            sym_ready, // Nibble taken this cycle.
	output dsl_lvl_t        resp_lvl,  // Current level, registered.
	output logic            resp_busy  // Symbol on the line.
);
	localparam int            CW   = $clog2(CHIP_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(CHIP_CYC - 1);

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} dsl_tx_state_t;

	typedef struct packed {
		dsl_tx_state_t st;
		logic [5:0]    chips;
		logic [1:0]    chip;
		logic [CW-1:0] cyc;
		dsl_lvl_t      lvl;
		logic          busy;
	} dsl_tx_st_t;

	localparam dsl_tx_st_t RST = '{TX_IDLE, 6'h00, 2'h0, '0, LVL_Q, 1'b0};

	dsl_tx_st_t s_ff;
	dsl_tx_st_t nxt_s;
	logic       sym_end;

	assign sym_end   = (s_ff.cyc == LAST) && (s_ff.chip == 2'h2);
	assign sym_ready = (s_ff.st == TX_IDLE) || (s_ff.st == TX_SEND && sym_end);
	assign resp_lvl  = s_ff.lvl;
	assign resp_busy = s_ff.busy;

	always_comb begin
		nxt_s = s_ff;
		unique case (s_ff.st)
			TX_IDLE: begin
				nxt_s.lvl = LVL_Q;
			end
			TX_SEND: begin
				if (s_ff.cyc != LAST) begin
					nxt_s.cyc = s_ff.cyc + 1'b1;
				end else if (s_ff.chip != 2'h2) begin
					nxt_s.cyc   = '0;
					nxt_s.chip  = s_ff.chip + 1'b1;
					nxt_s.chips = {s_ff.chips[3:0], 2'b00};
					nxt_s.lvl   = dsl_lvl_t'(s_ff.chips[3:2]);
				end else begin
					nxt_s.st   = TX_IDLE;
					nxt_s.lvl  = LVL_Q;
					nxt_s.busy = 1'b0;
				end
			end
		endcase
		// Back-to-back symbols follow without a quiescent gap.
		if (sym_valid && sym_ready) begin
			nxt_s.st    = TX_SEND;
			nxt_s.chips = SYM_TAB[sym_data];
			nxt_s.lvl   = dsl_lvl_t'(SYM_TAB[sym_data][5:4]);
			nxt_s.chip  = 2'h0;
			nxt_s.cyc   = '0;
			nxt_s.busy  = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	property p_first_chip;
		@(posedge ref_clk) disable iff (!rst_n)
		sym_valid && sym_ready |=> resp_lvl != LVL_Q;
	endproperty
	a_first_chip: assert property (p_first_chip)
		else $error("symbol opened with a quiescent chip");

	property p_chip_map;
		@(posedge ref_clk) disable iff (!rst_n)
		sym_valid && sym_ready |=>
			resp_lvl == dsl_lvl_t'(SYM_TAB[$past(sym_data)][5:4]);
	endproperty
	a_chip_map: assert property (p_chip_map)
		else $error("first chip does not match the nibble");

	property p_chip_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		s_ff.st == TX_SEND && s_ff.cyc != LAST |=> $stable(resp_lvl);
	endproperty
	a_chip_hold: assert property (p_chip_hold)
		else $error("chip level changed inside a chip time");

endmodule

// file: hdl/dsl_top.sv
`timescale 1ns/100ps
// How it works
// - One master talks to one addressed node to read and write registers.
// - Command is 32 bits: address, command, extended byte, data byte, CRC.
// - A command is taken only when its address equals the node address.
// - CRC runs over all 32 received bits, first bit first.
// - A command with a bad CRC is dropped without any response.
// - Seed preset, message and CRC shifted in; zero remainder means good.
// - Polynomial x^8+x^5+x^3+x^2+x+1 with all-ones seed.
// - Each reply is a 32-bit frame laid out like the command.
// - Each nibble goes out as three chips of three current levels.
// - Every symbol starts non-null and holds a level change.
// - Nibbles 0..F map to the fixed sixteen chip triples.
// - Reply carries own address and echoes the received command code.
// - Reply CRC: same polynomial, all-ones seed, eight zeros appended.
module dsl_top import dsl_pkg::*; #(
	parameter int CHIP_CYC = CHIP_CYCLES,
	parameter int FDEPTH   = FIFO_DEPTH
) (
	input  wire logic        ref_clk,              // Clock, 100 MHz.
	input  wire logic        rst_n,                // Async reset, active low.
	input  wire logic        cmd_frame_start,      // New command frame.
	input  wire logic        cmd_bit_valid,        // Decoded bit present.
	input  wire logic        cmd_bit,              // Decoded bit value.
	input  wire logic [3:0]  node_address_otp_reg, // Assigned node address.
	output dsl_reg_req_t     reg_req,              // Register access request.
	input  wire logic        reg_ack,              // Register access done.
	input  wire logic [15:0] reg_rdata,            // Data at addr+1, addr.
	output dsl_lvl_t         resp_lvl,             // Response current level.
	output logic             resp_busy,            // Response symbol active.
	output logic             cmd_reject            // Command dropped, pulse.
);
	typedef struct packed {
		dsl_state_t   st;
		logic [5:0]   cnt;
		logic [31:0]  sh;
		logic [7:0]   crc;
		dsl_frame_t   resp;
		logic [2:0]   idx;
		dsl_reg_req_t req;
		logic         reject;
	} dsl_top_st_t;

	localparam dsl_top_st_t RST = '{
		st:     DSL_RX,
		cnt:    6'h00,
		sh:     32'h0000_0000,
		crc:    CRC_SEED,
		resp:   '0,
		idx:    3'h0,
		req:    '0,
		reject: 1'b0
	};

	dsl_top_st_t s_ff;
	dsl_top_st_t nxt_s;
	dsl_frame_t  rx;
	logic [31:0] resp_shl;
	logic        frame_ok;
	logic        fifo_in_valid;
	logic [3:0]  fifo_in_data;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [3:0]  fifo_out_data;
	logic        fifo_out_ready;

	assign rx       = s_ff.sh;
	assign resp_shl = s_ff.resp << {s_ff.idx, 2'b00};
	assign frame_ok = (s_ff.crc == 8'h00) &&
		(rx.addr == node_address_otp_reg);
	assign reg_req    = s_ff.req;
	assign cmd_reject = s_ff.reject;

	always_comb begin
		nxt_s         = s_ff;
		nxt_s.reject  = 1'b0;
		fifo_in_valid = 1'b0;
		fifo_in_data  = resp_shl[31:28];
		unique case (s_ff.st)
			DSL_RX: begin
				// A start pulse wins over a bit in the same cycle.
				if (cmd_frame_start) begin
					nxt_s.cnt = 6'h00;
					nxt_s.crc = CRC_SEED;
				end else if (cmd_bit_valid) begin
					nxt_s.sh  = {s_ff.sh[30:0], cmd_bit};
					nxt_s.crc = dsl_crc_step(s_ff.crc, cmd_bit);
					nxt_s.cnt = s_ff.cnt + 6'h01;
					if (s_ff.cnt == 6'(FRAME_BITS - 1)) begin
						nxt_s.st = DSL_CHK;
					end
				end
			end
			DSL_CHK: begin
				nxt_s.cnt = 6'h00;
				nxt_s.crc = CRC_SEED;
				if (frame_ok) begin
					nxt_s.resp = '{node_address_otp_reg, rx.cmd, rx.ext,
						rx.data, 8'h00};
					if (rx.cmd == CMD_READ) begin
						nxt_s.req = '{1'b1, 1'b0, {rx.ext[7:1], 1'b0},
							8'h00};
						nxt_s.st  = DSL_REG;
					end else if (rx.cmd == CMD_WRITE) begin
						nxt_s.req = '{1'b1, 1'b1, rx.ext, rx.data};
						nxt_s.st  = DSL_REG;
					end else begin
						nxt_s.st = DSL_CRC;
					end
				end else begin
					nxt_s.reject = 1'b1;
					nxt_s.st     = DSL_RX;
				end
			end
			DSL_REG: begin
				if (reg_ack) begin
					nxt_s.req.valid = 1'b0;
					if (!s_ff.req.wr) begin
						nxt_s.resp.ext  = reg_rdata[15:8];
						nxt_s.resp.data = reg_rdata[7:0];
					end
					nxt_s.st = DSL_CRC;
				end
			end
			DSL_CRC: begin
				nxt_s.resp.crc = dsl_crc_run({s_ff.resp[31:8], 8'h00});
				nxt_s.idx      = 3'h0;
				nxt_s.st       = DSL_PUSH;
			end
			DSL_PUSH: begin
				fifo_in_valid = 1'b1;
				if (fifo_in_ready) begin
					nxt_s.idx = s_ff.idx + 3'h1;
					if (s_ff.idx == 3'(NIB_PER_FRAME - 1)) begin
						nxt_s.st = DSL_RX;
					end
				end
			end
			default: begin
				nxt_s = RST;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	dsl_fifo #(
		.W     (4),
		.DEPTH (FDEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (fifo_in_valid),
		.in_data   (fifo_in_data),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (fifo_out_ready)
	);

	dsl_chip_tx #(
		.CHIP_CYC (CHIP_CYC)
	) u_tx (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.sym_valid (fifo_out_valid),
		.sym_data  (fifo_out_data),
		.sym_ready (fifo_out_ready),
		.resp_lvl  (resp_lvl),
		.resp_busy (resp_busy)
	);

	default clocking dsl_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_bad_crc_drop;
		s_ff.st == DSL_CHK && s_ff.crc != 8'h00 |=>
			cmd_reject && s_ff.st == DSL_RX ##1 !fifo_in_valid;
	endproperty
	a_bad_crc_drop: assert property (p_bad_crc_drop)
		else $error("bad CRC frame was not dropped");

	property p_addr_drop;
		s_ff.st == DSL_CHK && rx.addr != node_address_otp_reg |=>
			!reg_req.valid && s_ff.st == DSL_RX;
	endproperty
	a_addr_drop: assert property (p_addr_drop)
		else $error("foreign address frame was acted on");

	property p_req_cause;
		$rose(reg_req.valid) |-> $past(s_ff.st) == DSL_CHK &&
			$past(rx.addr) == node_address_otp_reg;
	endproperty
	a_req_cause: assert property (p_req_cause)
		else $error("register access without address match");

	property p_read_req;
		s_ff.st == DSL_CHK && frame_ok && rx.cmd == CMD_READ |=>
			reg_req.valid && !reg_req.wr &&
			reg_req.addr == ($past(rx.ext) & 8'hfe);
	endproperty
	a_read_req: assert property (p_read_req)
		else $error("read request address wrong");

	property p_write_req;
		s_ff.st == DSL_CHK && frame_ok && rx.cmd == CMD_WRITE |=>
			reg_req.valid && reg_req.wr &&
			reg_req.addr == $past(rx.ext) && reg_req.wdata == $past(rx.data);
	endproperty
	a_write_req: assert property (p_write_req)
		else $error("write request fields wrong");

	property p_frame_len;
		s_ff.st == DSL_RX && cmd_frame_start |=>
			s_ff.cnt == 6'h00 && s_ff.crc == CRC_SEED;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame start did not preset the checker");

	property p_chk_after_32;
		s_ff.st == DSL_CHK |-> $past(s_ff.cnt) == 6'(FRAME_BITS - 1);
	endproperty
	a_chk_after_32: assert property (p_chk_after_32)
		else $error("frame judged before 32 bits");

	property p_resp_head;
		s_ff.st == DSL_PUSH |-> s_ff.resp.addr == node_address_otp_reg;
	endproperty
	a_resp_head: assert property (p_resp_head)
		else $error("response address is not the node address");

	property p_resp_crc;
		s_ff.st == DSL_PUSH |-> dsl_crc_run(s_ff.resp) == 8'h00;
	endproperty
	a_resp_crc: assert property (p_resp_crc)
		else $error("response CRC inconsistent");

	property p_first_nibble;
		s_ff.st == DSL_CRC |=> fifo_in_valid &&
			fifo_in_data == node_address_otp_reg;
	endproperty
	a_first_nibble: assert property (p_first_nibble)
		else $error("response does not open with the address nibble");

	property p_reject_pulse;
		cmd_reject |=> !cmd_reject;
	endproperty
	a_reject_pulse: assert property (p_reject_pulse)
		else $error("reject pulse longer than one cycle");

	property p_reject_no_req;
		cmd_reject |-> !reg_req.valid && !fifo_in_valid;
	endproperty
	a_reject_no_req: assert property (p_reject_no_req)
		else $error("dropped frame came with an access");

	property p_req_hold;
		reg_req.valid && !reg_ack |=> reg_req.valid && $stable(reg_req);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("register request changed before its answer");

	property p_req_drop;
		reg_req.valid && reg_ack |=> !reg_req.valid;
	endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("register request held after its answer");

	property p_nibble_order;
		fifo_in_valid |->
			fifo_in_data == s_ff.resp[31 - 4 * s_ff.idx -: 4];
	endproperty
	a_nibble_order: assert property (p_nibble_order)
		else $error("response nibble out of order");

	property p_push_len;
		s_ff.st == DSL_PUSH && s_ff.idx == 3'h7 && fifo_in_ready |=>
			s_ff.st == DSL_RX;
	endproperty
	a_push_len: assert property (p_push_len)
		else $error("response longer than eight symbols");

	property p_resp_echo;
		s_ff.st == DSL_PUSH |-> s_ff.resp.cmd == rx.cmd;
	endproperty
	a_resp_echo: assert property (p_resp_echo)
		else $error("response does not echo the command code");

	property p_rx_frozen;
		s_ff.st != DSL_RX |=> $stable(s_ff.sh);
	endproperty
	a_rx_frozen: assert property (p_rx_frozen)
		else $error("bits taken while a frame is being answered");

	c_read: cover property (s_ff.st == DSL_REG && reg_ack && !reg_req.wr);
	c_write: cover property (s_ff.st == DSL_REG && reg_ack && reg_req.wr);
	c_reject: cover property (cmd_reject);
	c_stall: cover property (fifo_in_valid && !fifo_in_ready);
	c_other: cover property (s_ff.st == DSL_CHK && frame_ok &&
		rx.cmd != CMD_READ && rx.cmd != CMD_WRITE);

endmodule

// file: tb/dsl_master_model.sv
`timescale 1ns/100ps
module dsl_master_model import dsl_pkg::*; #(
	parameter int CHIP_CYC = 3
) (
	input  wire logic     ref_clk,         // Clock.
	output logic          cmd_frame_start, // Frame start pulse.
	output logic          cmd_bit_valid,   // Bit strobe.
	output logic          cmd_bit,         // Bit value.
	input  wire dsl_lvl_t resp_lvl,        // Response current level.
	input  wire logic     resp_busy        // Response symbol active.
);
	dsl_lvl_t chips[$];
	int       cyc;

	initial begin
		cmd_frame_start = 1'b0;
		cmd_bit_valid   = 1'b0;
		cmd_bit         = 1'b0;
		cyc             = 0;
	end

	// Sends the top nbits of a frame; a short count leaves a partial frame.
	task automatic send(input logic [31:0] f, input int nbits);
		@(posedge ref_clk);
		cmd_frame_start <= 1'b1;
		@(posedge ref_clk);
		cmd_frame_start <= 1'b0;
		for (int i = 31; i >= 32 - nbits; i--) begin
			cmd_bit_valid <= 1'b1;
			cmd_bit       <= f[i];
			@(posedge ref_clk);
		end
		cmd_bit_valid <= 1'b0;
		// An idle data line never keeps showing the last bit.
		cmd_bit       <= ~f[32 - nbits];
	endtask

	// Samples each chip in the middle of its time while a response runs.
	always @(posedge ref_clk) begin
		if (resp_busy === 1'b1) begin
			if (cyc % CHIP_CYC == 1)
				chips.push_back(resp_lvl);
			cyc = cyc + 1;
		end else begin
			cyc = 0;
		end
	end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp, what) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("unexpected at %0t: %s", $time, what); \
		end \
	end
module tb_top import dsl_pkg::*; ();
	localparam int CC = 3;
	localparam int SYM[16] = '{110, 211, 102, 202, 100, 212, 112, 201,
		220, 210, 122, 221, 120, 200, 101, 121};

	logic         ref_clk;
	logic         rst_n;
	logic [3:0]   node_addr;
	logic         reg_ack = 1'b0;
	logic [15:0]  reg_rdata;
	dsl_reg_req_t reg_req;
	dsl_reg_req_t req_seen;
	dsl_lvl_t     resp_lvl;
	logic         resp_busy;
	logic         cmd_reject;
	logic         cmd_frame_start;
	logic         cmd_bit_valid;
	logic         cmd_bit;
	int           n_fail;
	int           n_compared;
	int           n_req = 0;
	int           n_rej = 0;

	dsl_top #(.CHIP_CYC(CC), .FDEPTH(16)) i_dsl_top (
		.ref_clk(ref_clk), .rst_n(rst_n),
		.cmd_frame_start(cmd_frame_start), .cmd_bit_valid(cmd_bit_valid),
		.cmd_bit(cmd_bit), .node_address_otp_reg(node_addr),
		.reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
		.resp_lvl(resp_lvl), .resp_busy(resp_busy),
		.cmd_reject(cmd_reject));

	dsl_master_model #(.CHIP_CYC(CC)) i_master (
		.ref_clk(ref_clk), .cmd_frame_start(cmd_frame_start),
		.cmd_bit_valid(cmd_bit_valid), .cmd_bit(cmd_bit),
		.resp_lvl(resp_lvl), .resp_busy(resp_busy));

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	// Answers each register request one cycle after it appears.
	always @(posedge ref_clk) begin
		reg_ack <= reg_req.valid && !reg_ack;
		if (reg_req.valid && reg_ack) begin
			req_seen <= reg_req;
			n_req    <= n_req + 1;
		end
		if (cmd_reject === 1'b1)
			n_rej <= n_rej + 1;
	end

	function automatic logic [7:0] crc8(input logic [31:0] m);
		logic [7:0] c;
		c = CRC_SEED;
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], m[i]} ^ (c[7] ? CRC_POLY : 8'h00);
		return c;
	endfunction

	function automatic logic [31:0] mk(input logic [23:0] m);
		return {m, crc8({m, 8'h00})};
	endfunction

	function automatic logic [1:0] dig(input int code, input int k);
		return 2'((k == 0 ? code / 100 : k == 1 ? code / 10 : code) % 10);
	endfunction

	task automatic finish_test();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic xfer(input logic [31:0] f);
		i_master.chips.delete();
		i_master.send(f, 32);
	endtask

	task automatic wait_done(input int want);
		int t;
		t = 0;
		if (want == 0)
			repeat (60) @(posedge ref_clk);
		while (i_master.chips.size() < want && t < 400) begin
			@(posedge ref_clk);
			t++;
		end
		repeat (2 * CC + 4) @(posedge ref_clk);
		`CHK(i_master.chips.size(), want, "chip count")
		`CHK(resp_busy, 1'b0, "busy after frame")
	endtask

	task automatic chk_resp(input logic [23:0] m);
		logic [31:0] f;
		int          code;
		f = mk(m);
		for (int n = 0; n < 8; n++) begin
			code = SYM[f[31 - 4 * n -: 4]];
			for (int k = 0; k < 3; k++)
				`CHK(i_master.chips[3 * n + k], dig(code, k), "chip")
			`CHK(i_master.chips[3 * n] != LVL_Q, 1'b1, "null 1st")
		end
	endtask

	task automatic expect_drop(input logic [31:0] f);
		int r0;
		int q0;
		r0 = n_rej;
		q0 = n_req;
		xfer(f);
		wait_done(0);
		`CHK(n_rej, r0 + 1, "one reject pulse")
		`CHK(n_req, q0, "access on dropped frame")
	endtask

	task automatic t_reset();
		@(posedge ref_clk);
		#1;
		`CHK(resp_lvl, LVL_Q, "level after reset")
		`CHK(resp_busy, 1'b0, "busy after reset")
		`CHK(reg_req, 18'h0, "request after reset")
	endtask

	task automatic t_write();
		int q0;
		q0 = n_req;
		`CHK(mk(24'h181186), 32'h181186b0, "crc example")
		xfer(32'h181186b0);
		wait_done(24);
		`CHK(n_req, q0 + 1, "write count")
		`CHK(req_seen, {2'b11, 16'h1186}, "write request")
		chk_resp(24'h181186);
	endtask

	task automatic t_read();
		reg_rdata <= 16'hc3a5;
		xfer(mk(24'h102500));
		wait_done(24);
		`CHK(req_seen.wr, 1'b0, "read kind")
		`CHK(req_seen.addr, 8'h24, "read address")
		chk_resp(24'h10c3a5);
	endtask

	task automatic t_drops();
		expect_drop(mk(24'h181186) ^ 32'h1);
		expect_drop(mk(24'h181186) ^ 32'h100);
		expect_drop(mk(24'h281186));
		expect_drop(mk(24'h081186));
	endtask

	task automatic t_other_cmds();
		logic [23:0] m;
		int          q0;
		q0 = n_req;
		for (int c = 1; c < 16; c++) begin
			if (c == 8)
				continue;
			m = {4'h1, 4'(c), 16'h5ac3};
			xfer(mk(m));
			wait_done(24);
			chk_resp(m);
		end
		`CHK(n_req, q0, "access on other command")
	endtask

	task automatic t_restart();
		i_master.send(mk(24'h18ffff), 12);
		xfer(32'h181186b0);
		wait_done(24);
		chk_resp(24'h181186);
	endtask

	task automatic t_other_node();
		node_addr <= 4'h2;
		xfer(mk(24'h281186));
		wait_done(24);
		chk_resp(24'h281186);
		expect_drop(mk(24'h181186));
		node_addr <= 4'h1;
	endtask

	initial begin
		rst_n      = 1'b0;
		node_addr  = 4'h1;
		reg_rdata  = 16'h0;
		n_fail     = 0;
		n_compared = 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_write();
		t_read();
		t_drops();
		t_other_node();
		t_other_cmds();
		t_restart();
		finish_test();
	end

	initial begin
		#500000;
		n_fail++;
		finish_test();
	end
endmodule
